// ---- hdl/adc_output_and_config_port.sv ----
// Digital output and configuration port of a 16-bit sampling converter.
// Assumes sample_i and sample_ovr_i come from the converter core on clk_i;
// all pins are asynchronous and are synchronised here.
`timescale 1ns/1ns
`include "adc_port_defs.svh"
module adc_output_and_config_port
#(
	parameter int LATENCY    = `PIPE_LATENCY,
	parameter int NAP_CYC    = `NAP_CYC,
	parameter int PIN_STABLE = `PIN_STABLE_CYC
)
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	// Configuration pins
	input  wire logic        prog_mode_strap_i,
	input  wire logic        cs_n_i,
	input  wire logic        sck_i,
	input  wire logic        sdi_i,
	input  wire logic        sdo_i,
	output logic             sdo_o,
	output logic             sdo_oe_n_o,
	// Encode clock pair
	input  wire logic        encode_pos_i,
	input  wire logic        encode_neg_i,
	// Converter core result
	input  wire logic [15:0] sample_i,
	input  wire logic        sample_ovr_i,
	// Data port
	output logic [15:0]      data_o,
	output logic [7:0]       ddr_bit_pair_lane_o,
	output logic [7:0]       ddr_bit_pair_lane_n_o,
	output logic             fwd_clock_pos_o,
	output logic             fwd_clock_neg_o,
	output logic             range_exceeded_flag_o,
	// Mode state to the analog side
	output logic             dcs_enable_o,
	output logic [1:0]       out_mode_o,
	output logic [1:0]       power_mode_o,
	output logic [2:0]       lvds_current_o,
	output logic             lvds_term_o
);

	localparam int PIN_W = 7;
	localparam int P_STRAP = 6;
	localparam int P_ENCP = 5;
	localparam int P_ENCN = 4;
	localparam int P_CS = 3;
	localparam int P_SCK = 2;
	localparam int P_SDI = 1;
	localparam int P_SDO = 0;

	logic [PIN_W-1:0]              pin_meta_reg;
	logic [PIN_W-1:0]              pin_s_reg;
	logic                          enc_d_reg;
	logic                          enc_lvl;
	logic                          enc_rise;
	logic                          enc_fall;
	logic                          par_mode;
	logic [3:0]                    par_pins;
	logic [3:0]                    par_last_reg;
	logic [7:0]                    stable_cnt_reg;
	adc_port_pkg::cfg_t            par_cfg_reg;
	adc_port_pkg::cfg_t            spi_cfg;
	adc_port_pkg::cfg_t            cfg_reg;
	adc_port_pkg::result_t         pipe_reg [LATENCY];
	adc_port_pkg::result_t         ddr_word_reg;
	logic [8:0]                    idle_cnt_reg;
	logic                          enc_stopped;
	logic                          ddr_mode;
	logic                          fwd_next;
	logic [2:0]                    fwd_hist_reg;
	logic                          fwd_phased;
	logic [7:0]                    lane_even;
	logic [7:0]                    lane_odd;

	// Two flip-flops on every pin before any logic looks at it
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			pin_meta_reg <= 7'h08; // Chip select parks high, so reset does not select the port
			pin_s_reg    <= 7'h08;
		end
		else
		begin
			pin_meta_reg <= {prog_mode_strap_i, encode_pos_i, encode_neg_i,
				cs_n_i, sck_i, sdi_i, sdo_i};
			pin_s_reg    <= pin_meta_reg;
		end
	end

	// Differential encode: high when the positive leg is above the negative one
	assign enc_lvl  = pin_s_reg[P_ENCP] & ~pin_s_reg[P_ENCN];
	assign enc_rise = enc_lvl & ~enc_d_reg;
	assign enc_fall = ~enc_lvl & enc_d_reg;
	assign par_mode = pin_s_reg[P_STRAP];
	assign par_pins = pin_s_reg[P_CS:P_SDO];

	always_ff @(posedge clk_i)
		enc_d_reg <= srst_i ? 1'b0 : enc_lvl;

	// Serial configuration port, live only while the strap is low
	spi_cfg_slave i_spi_cfg_slave
	(
		.clk_i      (clk_i),
		.srst_i     (srst_i),
		.active_i   (~par_mode),
		.cs_n_i     (pin_s_reg[P_CS]),
		.sck_i      (pin_s_reg[P_SCK]),
		.sdi_i      (pin_s_reg[P_SDI]),
		.cfg_o      (spi_cfg),
		.sdo_o      (sdo_o),
		.sdo_oe_n_o (sdo_oe_n_o)
	);

	// Parallel pins map onto a reduced mode set
	function automatic adc_port_pkg::cfg_t par_decode(input logic [3:0] p);
		adc_port_pkg::cfg_t c;
		c              = '0;
		c.dcs_on       = p[3];
		c.out_mode     = p[2] ? adc_port_pkg::OUT_DDR_LVDS : adc_port_pkg::OUT_CMOS;
		c.lvds_current = 3'h0;
		c.lvds_term    = 1'b0;
		unique case (p[1:0])
			2'b00:   c.power = adc_port_pkg::PWR_ON;
			2'b01:   c.power = adc_port_pkg::PWR_NAP;
			2'b10:   c.power = adc_port_pkg::PWR_ON;
			2'b11:   c.power = adc_port_pkg::PWR_SLEEP;
		endcase
		return c;
	endfunction : par_decode

	// Parallel levels are applied once they hold still, with no serial clock needed
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			par_last_reg   <= 4'h0;
			stable_cnt_reg <= 8'h00;
			par_cfg_reg    <= '0;
		end
		else
		begin
			par_last_reg <= par_pins;
			if (par_pins != par_last_reg)
				stable_cnt_reg <= 8'h00;
			else if (stable_cnt_reg != 8'(PIN_STABLE))
				stable_cnt_reg <= stable_cnt_reg + 8'h01;
			if (stable_cnt_reg == 8'(PIN_STABLE - 1))
				par_cfg_reg <= par_decode(par_last_reg);
		end
	end

	// Active configuration follows the strap
	always_ff @(posedge clk_i)
		cfg_reg <= srst_i ? '0 : (par_mode ? par_cfg_reg : spi_cfg);

	// Encode idle detector; a slow or stopped clock forces nap
	always_ff @(posedge clk_i)
	begin
		if (srst_i || enc_rise)
			idle_cnt_reg <= 9'h000;
		else if (!enc_stopped)
			idle_cnt_reg <= idle_cnt_reg + 9'h001;
	end
	assign enc_stopped = (idle_cnt_reg == 9'(NAP_CYC));

	// Mode outputs; sleep outranks nap, nap outranks normal running
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			dcs_enable_o   <= 1'b0;
			out_mode_o     <= 2'h0;
			power_mode_o   <= 2'h0;
			lvds_current_o <= 3'h0;
			lvds_term_o    <= 1'b0;
		end
		else
		begin
			dcs_enable_o   <= cfg_reg.dcs_on;
			out_mode_o     <= cfg_reg.out_mode;
			lvds_current_o <= cfg_reg.lvds_current;
			lvds_term_o    <= cfg_reg.lvds_term;
			if (cfg_reg.power == adc_port_pkg::PWR_SLEEP)
				power_mode_o <= adc_port_pkg::PWR_SLEEP;
			else if (enc_stopped)
				power_mode_o <= adc_port_pkg::PWR_NAP;
			else
				power_mode_o <= cfg_reg.power;
		end
	end

	// Result pipeline, one stage per encode rising edge
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			for (int i = 0; i < LATENCY; i++)
				pipe_reg[i] <= '0;
		end
		else if (enc_rise)
		begin
			pipe_reg[0] <= '{ovr: sample_ovr_i, data: sample_i};
			for (int i = 1; i < LATENCY; i++)
				pipe_reg[i] <= pipe_reg[i-1];
		end
	end

	// Lane split: lane g carries bits 2g and 2g+1
	function automatic logic [7:0] pick_bits(input logic [15:0] w, input logic odd);
		logic [7:0] r;
		r = 8'h00;
		for (int g = 0; g < 8; g++)
			r[g] = w[2*g + (odd ? 1 : 0)];
		return r;
	endfunction : pick_bits

	assign ddr_mode = (cfg_reg.out_mode == adc_port_pkg::OUT_DDR_CMOS)
		|| (cfg_reg.out_mode == adc_port_pkg::OUT_DDR_LVDS);
	assign lane_even = pick_bits(ddr_word_reg.data, 1'b0);
	assign lane_odd  = pick_bits(ddr_word_reg.data, 1'b1);

	// Forwarded clock before the phase delay: falls with full-rate data,
	// follows the encode level in DDR so that even bits sit under the low half
	always_comb
	begin
		fwd_next = fwd_hist_reg[0];
		if (enc_rise)
			fwd_next = ddr_mode;
		else if (enc_fall)
			fwd_next = ~ddr_mode;
	end

	// Phase delay in whole clock cycles, a coarse stand-in for analog delay taps
	always_ff @(posedge clk_i)
		fwd_hist_reg <= srst_i ? 3'h0 : {fwd_hist_reg[1:0], fwd_next};

	always_comb
	begin
		unique case (cfg_reg.clk_phase)
			2'h0: fwd_phased = fwd_next;
			2'h1: fwd_phased = fwd_hist_reg[0];
			2'h2: fwd_phased = fwd_hist_reg[1];
			2'h3: fwd_phased = fwd_hist_reg[2];
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			fwd_clock_pos_o <= 1'b0;
			fwd_clock_neg_o <= 1'b1;
		end
		else
		begin
			fwd_clock_pos_o <= fwd_phased;
			fwd_clock_neg_o <= ~fwd_phased;
		end
	end

	// Data port; full rate updates on encode rise, DDR on both edges
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			data_o                <= 16'h0000;
			ddr_bit_pair_lane_o   <= 8'h00;
			ddr_bit_pair_lane_n_o <= 8'h00;
			range_exceeded_flag_o <= 1'b0;
			ddr_word_reg          <= '0;
		end
		else if (!ddr_mode)
		begin
			ddr_bit_pair_lane_o   <= 8'h00;
			ddr_bit_pair_lane_n_o <= 8'h00;
			if (enc_rise)
			begin
				data_o                <= pipe_reg[LATENCY-1].data;
				range_exceeded_flag_o <= pipe_reg[LATENCY-1].ovr;
			end
		end
		else
		begin
			data_o <= 16'h0000;
			if (enc_rise)
			begin
				ddr_word_reg        <= pipe_reg[LATENCY-1];
				ddr_bit_pair_lane_o <= lane_odd;
				ddr_bit_pair_lane_n_o <= (cfg_reg.out_mode == adc_port_pkg::OUT_DDR_LVDS)
					? ~lane_odd : 8'h00;
			end
			else if (enc_fall)
			begin
				ddr_bit_pair_lane_o   <= lane_even;
				ddr_bit_pair_lane_n_o <= (cfg_reg.out_mode == adc_port_pkg::OUT_DDR_LVDS)
					? ~lane_even : 8'h00;
				range_exceeded_flag_o <= ddr_word_reg.ovr;
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	sequence s_par_quiet;
		par_mode && $stable(par_pins) && $stable(cfg_reg.clk_phase);
	endsequence

	sequence s_ddr_rise;
		ddr_mode && cfg_reg.clk_phase == 2'h0 && enc_rise;
	endsequence

	a_fwd_inverse: assert property (fwd_clock_neg_o == !fwd_clock_pos_o)
		else $error("negative forwarded clock not inverted");
	a_conv_capture: assert property (enc_rise |=> pipe_reg[0].data == $past(sample_i))
		else $error("sample not captured on encode rise");
	a_full_rate_edge: assert property (!ddr_mode && cfg_reg.clk_phase == 2'h0 && enc_rise
		&& !$changed(cfg_reg) |=> !fwd_clock_pos_o && data_o == $past(pipe_reg[LATENCY-1].data))
		else $error("full-rate data not with forwarded clock fall");
	a_ddr_odd_high: assert property (s_ddr_rise |=> fwd_clock_pos_o
		&& ddr_bit_pair_lane_o == pick_bits($past(ddr_word_reg.data), 1'b1))
		else $error("odd bits not under forwarded clock high");
	a_ddr_even_low: assert property (ddr_mode && cfg_reg.clk_phase == 2'h0 && enc_fall
		|=> !fwd_clock_pos_o && ddr_bit_pair_lane_o == pick_bits(ddr_word_reg.data, 1'b0))
		else $error("even bits not under forwarded clock low");
	a_nap_entry: assert property (enc_stopped && !enc_rise |=> power_mode_o != 2'h0)
		else $error("stopped encode did not force nap");
	a_par_apply: assert property (s_par_quiet [*8] |-> ##[0:3]
		(dcs_enable_o == par_pins[3] && out_mode_o[1] == par_pins[2]))
		else $error("parallel pin level not applied");
	a_par_power: assert property (s_par_quiet [*8] ##0 par_pins[1:0] == 2'b11
		|-> ##[0:3] power_mode_o == 2'h3)
		else $error("parallel sleep not applied");

endmodule : adc_output_and_config_port

// ---- hdl/adc_port_defs.svh ----
// Offsets, field positions, reset values and timing counts of the converter output port.
// Assumes a 125 MHz system clock that samples every pin of the part.
// Summary of operation
// - Strap low turns the four configuration pins into a serial configuration port.
// - Strap high makes the four configuration pins static mode-select inputs.
// - A conversion starts on the rising edge of the encode input pair.
// - Serial clock edges shift data only while chip select is held low.
// - Serial data in is sampled on each serial clock rising edge.
// - Readback bits appear on serial data out for falling-edge capture.
// - Serial data out only pulls low or releases; an external pull-up makes ones.
// - In parallel mode the chip select level turns the duty cycle stabilizer on.
// - In parallel mode the serial clock level picks the output data mode.
// - In parallel mode serial data in and out levels pick the power-down state.
// - Full-rate mode drives sixteen bits in parallel, the top bit carrying the MSB.
// - Full-rate data changes with the forwarded clock falling edge, unless phase-delayed.
// - DDR CMOS lanes carry even bits while forwarded clock is low, odd while high.
// - DDR LVDS pairs carry even bits while forwarded clock is low, odd while high.
// - Both DDR modes update data on both forwarded clock edges.
// - A mode register setting delays the forwarded clock against the data.
// - The negative forwarded clock is the inverse of the positive one.
// - The range flag is high when the sample exceeded the input range.
// - LVDS mode offers a drive current setting and an optional 100 ohm termination.
// - Results appear six encode cycles later in full rate; in DDR the even bits after six and a half, the odd bits after seven.
// - In serial mode a timing register bit switches the duty cycle stabilizer.
// - Nap mode is entered when the encode clock stops or runs below about 500 kHz.
`ifndef ADC_PORT_DEFS_SVH
`define ADC_PORT_DEFS_SVH

// Serial register addresses
`define SPI_ADDR_RESET    7'h00
`define SPI_ADDR_POWER    7'h01
`define SPI_ADDR_TIMING   7'h02
`define SPI_ADDR_OUTPUT   7'h03

// Field positions
`define RESET_BIT         7
`define POWER_LSB         0
`define TIMING_DCS_BIT    0
`define TIMING_PHASE_LSB  1
`define OUTPUT_MODE_LSB   0
`define OUTPUT_CUR_LSB    2
`define OUTPUT_TERM_BIT   5

// Register reset values
`define POWER_RST         8'h00
`define TIMING_RST        8'h00
`define OUTPUT_RST        8'h00

// Timing
`define CLK_PERIOD_NS     8
`define NAP_PERIOD_NS     2000
`define NAP_CYC           (`NAP_PERIOD_NS / `CLK_PERIOD_NS)
`define PIN_STABLE_CYC    4
`define PIPE_LATENCY      6

`endif

// ---- hdl/adc_port_pkg.sv ----
// Types shared by the converter output port and its serial configuration slave.
// Assumes adc_port_defs.svh for the numeric constants.
package adc_port_pkg;

	typedef enum logic [1:0] {
		OUT_CMOS     = 2'h0,
		OUT_DDR_CMOS = 2'h1,
		OUT_DDR_LVDS = 2'h2
	} out_mode_t;

	typedef enum logic [1:0] {
		PWR_ON    = 2'h0,
		PWR_NAP   = 2'h1,
		PWR_SLEEP = 2'h3
	} power_t;

	typedef enum logic [2:0] {
		SPI_IDLE = 3'h1,
		SPI_ADDR = 3'h2,
		SPI_DATA = 3'h4
	} spi_state_t;

	// Active operating configuration
	typedef struct packed {
		logic       dcs_on;
		logic [1:0] clk_phase;
		out_mode_t  out_mode;
		logic [2:0] lvds_current;
		logic       lvds_term;
		power_t     power;
	} cfg_t;

	// One conversion result with its range flag
	typedef struct packed {
		logic        ovr;
		logic [15:0] data;
	} result_t;

endpackage : adc_port_pkg

// ---- hdl/spi_cfg_slave.sv ----
// Serial configuration slave holding the mode control registers.
// Assumes cs_n_i, sck_i and sdi_i are already synchronised to clk_i.
`timescale 1ns/1ns
`include "adc_port_defs.svh"
module spi_cfg_slave
(
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               srst_i,
	// Serial pins, synchronised
	input  wire logic               active_i,
	input  wire logic               cs_n_i,
	input  wire logic               sck_i,
	input  wire logic               sdi_i,
	// Outputs
	output adc_port_pkg::cfg_t      cfg_o,
	output logic                    sdo_o,
	output logic                    sdo_oe_n_o
);

	adc_port_pkg::spi_state_t state_reg;
	logic [7:0]               regs_reg [0:3];
	logic [7:0]               shift_reg;
	logic [7:0]               rd_reg;
	logic [3:0]               bit_cnt_reg;
	logic                     rw_reg;
	logic [6:0]               addr_reg;
	logic                     sck_d_reg;
	logic                     sck_rise;
	logic                     sck_fall;
	logic                     sel;
	logic [7:0]               byte_in;

	assign sck_rise = sck_i & ~sck_d_reg;
	assign sck_fall = ~sck_i & sck_d_reg;
	assign sel      = active_i & ~cs_n_i;
	assign byte_in  = {shift_reg[6:0], sdi_i};

	// Serial clock edge history
	always_ff @(posedge clk_i)
		sck_d_reg <= srst_i ? 1'b0 : sck_i;

	// Frame: read flag, 7-bit address, 8 data bits, MSB first
	always_ff @(posedge clk_i)
	begin
		if (srst_i || !sel)
		begin
			state_reg   <= adc_port_pkg::SPI_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg   <= 8'h00;
			rw_reg      <= 1'b0;
			addr_reg    <= 7'h00;
		end
		else
		begin
			// A rising edge may come in the very cycle that select arrives, so shift in any state
			unique case (state_reg)
				adc_port_pkg::SPI_IDLE: state_reg <= adc_port_pkg::SPI_ADDR;
				adc_port_pkg::SPI_ADDR: state_reg <= adc_port_pkg::SPI_ADDR;
				adc_port_pkg::SPI_DATA: state_reg <= adc_port_pkg::SPI_DATA;
			endcase
			if (sck_rise)
			begin
				shift_reg   <= byte_in;
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
				if (bit_cnt_reg == 4'h7)
				begin
					rw_reg    <= byte_in[7];
					addr_reg  <= byte_in[6:0];
					state_reg <= adc_port_pkg::SPI_DATA;
				end
				if (bit_cnt_reg == 4'hf)
					state_reg <= adc_port_pkg::SPI_ADDR;
			end
		end
	end

	// Register writes; a reset-register write restores every mode register
	always_ff @(posedge clk_i)
	begin
		if (srst_i || (sel && sck_rise && bit_cnt_reg == 4'hf && !rw_reg
			&& addr_reg == `SPI_ADDR_RESET && byte_in[`RESET_BIT]))
		begin
			regs_reg[0] <= 8'h00;
			regs_reg[1] <= `POWER_RST;
			regs_reg[2] <= `TIMING_RST;
			regs_reg[3] <= `OUTPUT_RST;
		end
		else if (sel && sck_rise && bit_cnt_reg == 4'hf && !rw_reg
			&& addr_reg[6:2] == 5'h00 && addr_reg != `SPI_ADDR_RESET)
			regs_reg[addr_reg[1:0]] <= byte_in;
	end

	// Readback: load after the address byte, drive only low, change on SCK fall
	always_ff @(posedge clk_i)
	begin
		sdo_o <= 1'b0;
		if (srst_i || !sel)
		begin
			rd_reg     <= 8'h00;
			sdo_oe_n_o <= 1'b1;
		end
		else if (sck_rise && bit_cnt_reg == 4'h7)
			rd_reg <= (byte_in[7] && byte_in[6:2] == 5'h00) ? regs_reg[byte_in[1:0]] : 8'hff;
		else if (sck_fall && state_reg == adc_port_pkg::SPI_DATA && rw_reg)
		begin
			sdo_oe_n_o <= rd_reg[7];
			rd_reg     <= {rd_reg[6:0], 1'b1};
		end
		else if (sck_fall && state_reg != adc_port_pkg::SPI_DATA)
			sdo_oe_n_o <= 1'b1;
	end

	// Register fields onto the configuration struct
	always_comb
	begin
		cfg_o.dcs_on       = regs_reg[2][`TIMING_DCS_BIT];
		cfg_o.clk_phase    = regs_reg[2][`TIMING_PHASE_LSB +: 2];
		cfg_o.out_mode     = adc_port_pkg::out_mode_t'(regs_reg[3][`OUTPUT_MODE_LSB +: 2]);
		cfg_o.lvds_current = regs_reg[3][`OUTPUT_CUR_LSB +: 3];
		cfg_o.lvds_term    = regs_reg[3][`OUTPUT_TERM_BIT];
		cfg_o.power        = adc_port_pkg::power_t'(regs_reg[1][`POWER_LSB +: 2]);
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	a_shift_sample: assert property (sel && sck_rise |=> shift_reg[0] == $past(sdi_i))
		else $error("serial bit not taken on sck rise");
	a_cs_gate: assert property (!sel |=> bit_cnt_reg == 4'h0 && !$changed(regs_reg[1]))
		else $error("shift while deselected");
	a_sdo_release: assert property (!sel |=> sdo_oe_n_o && !sdo_o)
		else $error("serial data out driven while deselected");

endmodule : spi_cfg_slave

// ---- tb/adc_far_side.sv ----
// Far-side model: encode source, configuration master, pull-up on the data-out line.
// Assumes the bench clock clk_i; serial and parallel pin changes land just after a falling clk edge.
`timescale 1ns/1ns
module adc_far_side
(
	// Clock
	input  wire logic clk_i,
	// Control from the bench
	input  wire logic enc_run_i,
	// Pins towards the converter
	output logic      encode_pos_o,
	output logic      encode_neg_o,
	output logic      cs_n_o,
	output logic      sck_o,
	output logic      sdi_o,
	// Open-drain data-out line
	input  wire logic sdo_oe_n_i,
	output logic      sdo_line_o
);
	logic drv_en;
	logic drv_val;

	// Pull-up makes released bits ones; a driven pin wins through its series resistor
	assign sdo_line_o = drv_en ? drv_val : sdo_oe_n_i;
	assign encode_neg_o = ~encode_pos_o;

	// Encode clock, 125 ns period; parked low while stopped
	initial
	begin
		encode_pos_o = 1'b0;
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		sdi_o = 1'b0;
		drv_en = 1'b0;
		drv_val = 1'b0;
		forever
		begin
			#63;
			encode_pos_o = enc_run_i;
			#62;
			encode_pos_o = 1'b0;
		end
	end

	// One frame, MSB first; sck half period of 16 clk keeps the period above the readback minimum
	task automatic xfer(input logic [15:0] word, output logic [7:0] rd);
		@(negedge clk_i);
		cs_n_o = 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			sdi_o = word[i];
			repeat (16) @(negedge clk_i);
			sck_o = 1'b1;
			repeat (16) @(negedge clk_i);
			if (i <= 7)
				rd = {rd[6:0], sdo_line_o};
			sck_o = 1'b0;
		end
		repeat (8) @(negedge clk_i);
		cs_n_o = 1'b1;
	endtask : xfer

	// Static levels for parallel programming
	task automatic set_pins(input logic [3:0] p);
		{cs_n_o, sck_o, sdi_o, drv_val} = p;
		drv_en = 1'b1;
	endtask : set_pins
endmodule : adc_far_side

// ---- tb/adc_output_and_config_port_bench.sv ----
// Self-checking bench for the converter output and configuration port.
// Assumes the far-side model and the design package and header.
`timescale 1ns/1ns
module adc_output_and_config_port_bench;
	logic        clk_i;
	logic        srst_i;
	logic        strap;
	logic        enc_run;
	logic        enc_pos;
	logic        enc_neg;
	logic        enc_prev;
	logic        cs_n;
	logic        sck;
	logic        sdi;
	logic        sdo_line;
	logic        sdo_o;
	logic        sdo_oe_n_o;
	logic [15:0] sample;
	logic        ovr;
	logic [15:0] data_o;
	logic [7:0]  lane;
	logic [7:0]  lane_n;
	logic        fwd_p;
	logic        fwd_n;
	logic        flag;
	logic        dcs;
	logic [1:0]  out_mode;
	logic [1:0]  power;
	logic [2:0]  cur;
	logic        term;
	logic [1:0]  mode_exp;
	logic        chk_en;
	logic [16:0] hist[$];
	int          mismatches;
	int          cmp_count;
	// Rows: address, data, then expected {dcs, mode, power, current, term}
	logic [24:0] ser_rows[8] = '{{8'h02, 8'h01, 9'h100}, {8'h03, 8'h3e, 9'h18f},
		{8'h01, 8'h01, 9'h19f}, {8'h01, 8'h03, 9'h1bf}, {8'h03, 8'h01, 9'h170},
		{8'h02, 8'h04, 9'h070}, {8'h01, 8'h00, 9'h040}, {8'h05, 8'h77, 9'h040}};
	// Rows: {cs, sck, sdi, sdo} levels, then expected {dcs, mode, power}
	logic [8:0]  par_rows[4] = '{{4'h0, 5'h00}, {4'h9, 5'h11}, {4'h6, 5'h08}, {4'hf, 5'h1b}};

	adc_output_and_config_port #(.NAP_CYC(20)) i_adc_output_and_config_port (
		.clk_i(clk_i), .srst_i(srst_i), .prog_mode_strap_i(strap), .cs_n_i(cs_n),
		.sck_i(sck), .sdi_i(sdi), .sdo_i(sdo_line), .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o),
		.encode_pos_i(enc_pos), .encode_neg_i(enc_neg), .sample_i(sample),
		.sample_ovr_i(ovr), .data_o(data_o), .ddr_bit_pair_lane_o(lane),
		.ddr_bit_pair_lane_n_o(lane_n), .fwd_clock_pos_o(fwd_p), .fwd_clock_neg_o(fwd_n),
		.range_exceeded_flag_o(flag), .dcs_enable_o(dcs), .out_mode_o(out_mode),
		.power_mode_o(power), .lvds_current_o(cur), .lvds_term_o(term));

	adc_far_side i_adc_far_side (.clk_i(clk_i), .enc_run_i(enc_run), .encode_pos_o(enc_pos),
		.encode_neg_o(enc_neg), .cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi),
		.sdo_oe_n_i(sdo_oe_n_o), .sdo_line_o(sdo_line));

	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_of_test();
		$display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	// Watch the data port for a while; only when powered, since nap or sleep may freeze it
	task automatic run_data(input logic [1:0] mode, input logic [1:0] pwr);
		if (pwr == 2'h0)
		begin
			mode_exp = mode;
			repeat (60) @(negedge clk_i);
			chk_en = 1'b1;
			repeat (200) @(negedge clk_i);
			chk_en = 1'b0;
		end
	endtask : run_data

	initial
	begin
		clk_i = 1'b0;
		forever
			#4 clk_i = ~clk_i;
	end

	// New sample after each encode fall, so it is steady at the next rise
	always @(negedge clk_i)
	begin
		if (enc_prev && !enc_pos)
		begin
			sample <= sample + 16'h1357;
			ovr <= sample[2];
		end
		enc_prev <= enc_pos;
	end

	// Samples in conversion order, as taken at each encode rise
	always @(posedge enc_pos)
	begin
		hist.push_back({ovr, sample});
		if (hist.size() > 16)
			void'(hist.pop_front());
	end

	// Data port against the sample history, at every forwarded clock edge
	always @(fwd_p)
	begin : watch_port
		logic [16:0] ref_s;
		logic [7:0]  lanes;
		#1;
		check(fwd_n, !fwd_p);
		if (chk_en && hist.size() > 8)
		begin
			ref_s = (fwd_p && mode_exp != 2'h0) ? hist[$-7] : hist[$-6];
			for (int g = 0; g < 8; g++)
				lanes[g] = ref_s[2 * g + (fwd_p ? 1 : 0)];
			if (!fwd_p)
				check(flag, ref_s[16]);
			if (mode_exp == 2'h0 && !fwd_p)
				check(data_o, ref_s[15:0]);
			if (mode_exp != 2'h0)
				check(lane, lanes);
			if (mode_exp == 2'h2)
				check(lane_n, 8'(~lanes));
			if (mode_exp == 2'h1)
				check(lane_n, 8'h00);
			// Unused half of the port must sit at zero in each mode
			if (mode_exp == 2'h0)
				check({lane, lane_n}, 16'h0000);
			else
				check(data_o, 16'h0000);
		end
	end

	// Hang guard
	initial
	begin
		repeat (50000) @(posedge clk_i);
		mismatches++;
		end_of_test();
	end

	initial
	begin
		logic [7:0] rd;
		srst_i = 1'b1;
		strap = 1'b0;
		enc_run = 1'b1;
		enc_prev = 1'b0;
		sample = 16'h0000;
		ovr = 1'b0;
		mode_exp = 2'h0;
		chk_en = 1'b0;
		mismatches = 0;
		cmp_count = 0;
		repeat (2) @(negedge clk_i);
		check({data_o, lane, lane_n, fwd_p, fwd_n, flag, sdo_oe_n_o, dcs, out_mode, power},
			{16'h0, 8'h0, 8'h0, 4'h5, 5'h00});
		srst_i = 1'b0;
		repeat (5) @(negedge clk_i);
		// Serial writes then readback, one register address at a time
		foreach (ser_rows[i])
		begin
			i_adc_far_side.xfer({1'b0, ser_rows[i][23:17], ser_rows[i][16:9]}, rd);
			i_adc_far_side.xfer({1'b1, ser_rows[i][23:17], 8'h00}, rd);
			repeat (6) @(negedge clk_i);
			check(rd, (ser_rows[i][24:17] > 8'h03) ? 8'hff : ser_rows[i][16:9]);
			check({sdo_o, sdo_oe_n_o}, 2'h1);
			check({dcs, out_mode, power, cur, term}, ser_rows[i][8:0]);
			run_data(ser_rows[i][7:6], ser_rows[i][5:4]);
		end
		// Stopped encode clock must drop the part into nap
		enc_run = 1'b0;
		repeat (60) @(negedge clk_i);
		check(power, 2'h1);
		enc_run = 1'b1;
		// Parallel programming by pin levels
		strap = 1'b1;
		foreach (par_rows[i])
		begin
			i_adc_far_side.set_pins(par_rows[i][8:5]);
			repeat (40) @(negedge clk_i);
			check({dcs, out_mode, power}, par_rows[i][4:0]);
			run_data(par_rows[i][3:2], par_rows[i][1:0]);
		end
		end_of_test();
	end
endmodule : adc_output_and_config_port_bench
